/* rtl/mpurp_unit.sv */
// Protection unit: interrupt enables and status, fixed range and programmable ranges, access check.
// Assumes requests come from the requester end on the same clock; reads answer one cycle later.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mpurp_unit #(
    parameter bit LARGE_PAGE = 1'b0
) (
    input  wire logic CLK,
    input  wire logic ARST_N,
    mpurp_if.unit     bus
);
    import mpurp_pkg::*;

    localparam int PB = LARGE_PAGE ? LARGE_PAGE_BITS : SMALL_PAGE_BITS;
    localparam int NR = LARGE_PAGE ? LARGE_RANGES : SMALL_RANGES;
    localparam int FW = AW - PB;
    localparam logic [FW-1:0] START_RST = LARGE_PAGE ? FW'(LARGE_START_RESET) : FW'(SMALL_START_RESET);
    localparam logic [FW-1:0] END_RST   = LARGE_PAGE ? FW'(LARGE_END_RESET) : FW'(SMALL_END_RESET);

    logic [1:0]    enable, next_enable;
    logic [1:0]    raw, next_raw;
    logic [DW-1:0] perm, next_perm;
    logic          assume_ok, next_assume_ok;
    logic [FW-1:0] rstart [NR], next_rstart [NR];
    logic [FW-1:0] rend   [NR], next_rend   [NR];
    logic [DW-1:0] rdata, next_rdata;
    logic          allow, next_allow;
    logic          done, next_done;

    // Only the fixed-range permissions are held; programmable ranges use the same permission word.
    function automatic logic perm_ok(input logic [DW-1:0] p, input logic [7:0] id,
                                     input logic sup, input logic [2:0] kind);
        logic id_ok;
        logic [2:0] acc;
        id_ok = (id < 8'(NUM_IDS)) ? p[PERM_ID_LSB + 32'(id[3:0])] : p[PERM_HIGH_ID]; // R9 R10
        acc = sup ? p[PERM_SR:PERM_SX] : p[PERM_UR:PERM_UX]; // R8
        return id_ok && ((acc & kind) == kind);
    endfunction

    function automatic logic wr_legal(input logic [FW-1:0] v);
        return LARGE_PAGE ? (v[15:0] >= LARGE_MIN && v[15:0] <= LARGE_MAX) : 1'b1; // R17
    endfunction

    always_comb begin
        logic in_fixed;
        logic in_prog;
        logic [FW-1:0] page;
        logic sup_wr;
        in_fixed = 1'b0;
        in_prog = 1'b0;
        page = bus.xfer_addr[AW-1:PB];
        sup_wr = bus.reg_wr && bus.reg_super;
        next_enable = enable;
        next_raw = raw;
        next_perm = perm;
        next_assume_ok = assume_ok;
        next_rstart = rstart;
        next_rend = rend;
        next_rdata = '0;
        next_allow = 1'b0;
        next_done = 1'b0;

        if (bus.reg_wr) begin
            case (bus.reg_addr)
                OFS_EN_SET: next_enable = enable | bus.reg_wdata[1:0]; // R1 R2
                OFS_EN_CLR: next_enable = enable & ~bus.reg_wdata[1:0]; // R3
                OFS_RAW_STAT: next_raw = raw | bus.reg_wdata[1:0]; // R20
                OFS_EN_STAT: next_raw = raw & ~bus.reg_wdata[1:0]; // R21
                OFS_CONFIG: next_assume_ok = bus.reg_wdata[BIT_ASSUME]; // R22
                OFS_FXD_PERM: begin
                    if (sup_wr) begin
                        next_perm = (bus.reg_wdata & PERM_WR_MASK) | PERM_RO_ONES; // R7
                    end
                end
                default: begin
                end
            endcase
            for (int i = 0; i < NR; i++) begin
                if (sup_wr && bus.reg_addr == RAW'(OFS_PROG_BASE + i * PROG_STRIDE)
                    && wr_legal(bus.reg_wdata[AW-1:PB])) begin
                    next_rstart[i] = bus.reg_wdata[AW-1:PB]; // R12 R14
                end
                if (sup_wr && bus.reg_addr == RAW'(OFS_PROG_BASE + i * PROG_STRIDE + 4)
                    && wr_legal(bus.reg_wdata[AW-1:PB])) begin
                    next_rend[i] = bus.reg_wdata[AW-1:PB]; // R18 R14
                end
            end
        end

        if (bus.reg_rd) begin
            case (bus.reg_addr)
                OFS_EN_SET, OFS_EN_CLR: next_rdata = {30'h0000_0000, enable}; // R1 R4
                OFS_RAW_STAT: next_rdata = {30'h0000_0000, raw};
                OFS_EN_STAT: next_rdata = {30'h0000_0000, raw & enable}; // R21
                OFS_CONFIG: next_rdata = {31'h0000_0000, assume_ok};
                OFS_FXD_START, OFS_FXD_END: next_rdata = '0; // R6
                OFS_FXD_PERM: next_rdata = perm;
                default: begin
                    for (int i = 0; i < NR; i++) begin
                        if (bus.reg_addr == RAW'(OFS_PROG_BASE + i * PROG_STRIDE)) begin
                            next_rdata = {rstart[i], {PB{1'b0}}}; // R16 R17
                        end
                        if (bus.reg_addr == RAW'(OFS_PROG_BASE + i * PROG_STRIDE + 4)) begin
                            next_rdata = {rend[i], {PB{1'b1}}};
                        end
                    end
                end
            endcase
        end

        if (bus.xfer_valid) begin
            in_fixed = (bus.xfer_addr >= FXD_LO) && (bus.xfer_addr <= FXD_HI); // R5
            for (int i = 0; i < NR; i++) begin
                if (page >= rstart[i] && page <= rend[i]) begin
                    in_prog = 1'b1; // R15
                end
            end
            if (in_fixed || in_prog) begin
                next_allow = perm_ok(perm, bus.xfer_id, bus.xfer_super, bus.xfer_kind);
                if (!next_allow) begin
                    next_raw[BIT_PERM_VIOL] = 1'b1;
                end
            end else begin
                next_allow = assume_ok; // R22
                if (!assume_ok) begin
                    next_raw[BIT_ADDR_VIOL] = 1'b1;
                end
            end
            next_done = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            enable <= 2'h0;
            raw <= 2'h0;
            perm <= PERM_RESET;
            assume_ok <= ASSUME_RESET;
            for (int i = 0; i < NR; i++) begin
                rstart[i] <= START_RST;
                rend[i] <= END_RST;
            end
            rdata <= '0;
            allow <= 1'b0;
            done <= 1'b0;
        end else begin
            enable <= next_enable;
            raw <= next_raw;
            perm <= next_perm;
            assume_ok <= next_assume_ok;
            rstart <= next_rstart;
            rend <= next_rend;
            rdata <= next_rdata;
            allow <= next_allow;
            done <= next_done;
        end
    end

    assign bus.reg_rdata = rdata;
    assign bus.xfer_allow = allow;
    assign bus.xfer_done = done;
    assign bus.irq = |(raw & enable); // R20 R23
endmodule
`default_nettype wire

/* rtl/mpurp_pkg.sv */
// Constants, register map and types shared by the protection unit and its requester end.
// Assumes one 100 MHz clock and an asynchronous active-low reset at both ends.
//
// Overview of operation
// R1: Enable-set read shows enables; write 1 sets.
// R2: Address enable bit 1, permission enable bit 0.
// R3: Enable-clear write 1 disables that interrupt.
// R4: Enable-clear read equals enable-set read.
// R5: Fixed range guards B000_0000h to B000_7FFFh.
// R6: Fixed start and end registers read zero.
// R7: Fixed permissions written only by supervisor.
// R8: Six access bits, supervisor 5-3, user 2-0.
// R9: Bits 21-10 grant requester IDs 0-11.
// R10: Bit 9 grants requester IDs above 11.
// R11: Software writes ones to bits 7 and 6.
// R12: Range start written only by supervisor.
// R13: Start addresses are page aligned by software.
// R14: Stored address field is page granular only.
// R15: End address is inclusive, page aligned.
// R16: Small-page start bits 31-10, reset 20_0000h.
// R17: Large-page start upper sixteen bits, C000h-DFFFh.
// R18: Range end written only by supervisor.
// R19: Software dedicates a range to unpopulated memory.
// R20: Interrupt needs raw status and enable; write sets.
// R21: Enabled-status reads masked; write 1 clears both.
// R22: Uncovered address allowed by configuration bit 0.
// R23: Interrupt output ORs enabled pending status bits.
package mpurp_pkg;
    localparam int AW = 32;
    localparam int DW = 32;
    localparam int RAW = 8;

    localparam logic [RAW-1:0] OFS_CONFIG     = 8'h04;
    localparam logic [RAW-1:0] OFS_RAW_STAT   = 8'h10;
    localparam logic [RAW-1:0] OFS_EN_STAT    = 8'h14;
    localparam logic [RAW-1:0] OFS_EN_SET     = 8'h18;
    localparam logic [RAW-1:0] OFS_EN_CLR     = 8'h1C;
    localparam logic [RAW-1:0] OFS_FXD_START  = 8'h20;
    localparam logic [RAW-1:0] OFS_FXD_END    = 8'h24;
    localparam logic [RAW-1:0] OFS_FXD_PERM   = 8'h28;
    localparam logic [RAW-1:0] OFS_PROG_BASE  = 8'h40;
    localparam int              PROG_STRIDE   = 8;

    localparam int BIT_ADDR_VIOL = 1;
    localparam int BIT_PERM_VIOL = 0;
    localparam int BIT_ASSUME    = 0;

    localparam int PERM_SR = 5;
    localparam int PERM_SW = 4;
    localparam int PERM_SX = 3;
    localparam int PERM_UR = 2;
    localparam int PERM_UW = 1;
    localparam int PERM_UX = 0;
    localparam int PERM_HIGH_ID = 9;
    localparam int PERM_ID_LSB  = 10;
    localparam int NUM_IDS      = 12;
    localparam logic [DW-1:0] PERM_WR_MASK = 32'h003F_FEFF;
    localparam logic [DW-1:0] PERM_RO_ONES = 32'h03C0_0000;
    localparam logic [DW-1:0] PERM_RESET   = 32'h03FF_FEFF;

    localparam logic [AW-1:0] FXD_LO = 32'hB000_0000;
    localparam logic [AW-1:0] FXD_HI = 32'hB000_7FFF;

    localparam int SMALL_PAGE_BITS = 10;
    localparam int LARGE_PAGE_BITS = 16;
    localparam int SMALL_RANGES    = 6;
    localparam int LARGE_RANGES    = 12;
    localparam logic [21:0] SMALL_START_RESET = 22'h20_0000;
    localparam logic [21:0] SMALL_END_RESET   = 22'h20_007F;
    localparam logic [15:0] LARGE_START_RESET = 16'hC000;
    localparam logic [15:0] LARGE_END_RESET   = 16'hDFFF;
    localparam logic [15:0] LARGE_MIN         = 16'hC000;
    localparam logic [15:0] LARGE_MAX         = 16'hDFFF;

    localparam logic ASSUME_RESET = 1'b1;

    typedef enum logic [2:0] {
        MPURP_IDLE = 3'b001,
        MPURP_WAIT = 3'b010,
        MPURP_DONE = 3'b100
    } mpurp_req_st_t;
endpackage

/* rtl/mpurp_if.sv */
// Joins the protection unit to the requester end: a register port and a checked transfer port.
// Assumes both ends share CLK and ARST_N.
`timescale 1ns/10ps
`default_nettype none
interface mpurp_if;
    import mpurp_pkg::*;
    logic          reg_wr;
    logic          reg_rd;
    logic [RAW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic [DW-1:0] reg_rdata;
    logic          reg_super;
    logic [7:0]    reg_id;
    logic          xfer_valid;
    logic [AW-1:0] xfer_addr;
    logic [7:0]    xfer_id;
    logic          xfer_super;
    logic [2:0]    xfer_kind;
    logic          xfer_allow;
    logic          xfer_done;
    logic          irq;

    modport unit (input reg_wr, reg_rd, reg_addr, reg_wdata, reg_super, reg_id,
                  xfer_valid, xfer_addr, xfer_id, xfer_super, xfer_kind,
                  output reg_rdata, xfer_allow, xfer_done, irq);
    modport requester (output reg_wr, reg_rd, reg_addr, reg_wdata, reg_super, reg_id,
                       xfer_valid, xfer_addr, xfer_id, xfer_super, xfer_kind,
                       input reg_rdata, xfer_allow, xfer_done, irq);
endinterface
`default_nettype wire

/* rtl/mpurp_requester.sv */
// Requester end: turns user commands into register accesses and checked transfers.
// Assumes the unit answers reads and transfers exactly one cycle after the request.
`timescale 1ns/10ps
`default_nettype none
module mpurp_requester (
    input  wire logic                    CLK,
    input  wire logic                    ARST_N,
    mpurp_if.requester                   bus,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    input  wire logic [mpurp_pkg::RAW-1:0] REG_ADDR,
    input  wire logic [mpurp_pkg::DW-1:0]  REG_WDATA,
    input  wire logic                    SUPER,
    input  wire logic [7:0]              ID,
    output logic [mpurp_pkg::DW-1:0]     REG_RDATA,
    input  wire logic                    XFER_REQ,
    input  wire logic [mpurp_pkg::AW-1:0] XFER_ADDR,
    input  wire logic [2:0]              XFER_KIND,
    output logic                         XFER_BUSY,
    output logic                         XFER_DONE,
    output logic                         XFER_ALLOW,
    output logic                         IRQ
);
    import mpurp_pkg::*;

    mpurp_req_st_t state, next_state;
    logic [DW-1:0] rdata, next_rdata;
    logic          allow, next_allow;
    logic          done, next_done;
    logic          rd_pend, next_rd_pend;

    always_comb begin
        next_state = state;
        next_rdata = rdata;
        next_allow = allow;
        next_done = 1'b0;
        next_rd_pend = REG_RD;
        if (rd_pend) begin
            next_rdata = bus.reg_rdata;
        end
        case (state)
            MPURP_IDLE: begin
                if (XFER_REQ) begin
                    next_state = MPURP_WAIT;
                end
            end
            MPURP_WAIT: begin
                if (bus.xfer_done) begin
                    next_allow = bus.xfer_allow;
                    next_done = 1'b1;
                    next_state = MPURP_DONE;
                end
            end
            MPURP_DONE: next_state = MPURP_IDLE;
            default: next_state = MPURP_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= MPURP_IDLE;
            rdata <= '0;
            allow <= 1'b0;
            done <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            state <= next_state;
            rdata <= next_rdata;
            allow <= next_allow;
            done <= next_done;
            rd_pend <= next_rd_pend;
        end
    end

    // Supervisor privilege travels with each register write; the unit filters it. R7 R12 R18
    assign bus.reg_wr = REG_WR;
    assign bus.reg_rd = REG_RD;
    assign bus.reg_addr = REG_ADDR;
    // Reserved permission bits 7 and 6 are forced to one on the way out. R11
    assign bus.reg_wdata = (REG_ADDR == OFS_FXD_PERM) ? (REG_WDATA | 32'h0000_00C0) : REG_WDATA;
    assign bus.reg_super = SUPER;
    assign bus.reg_id = ID;
    assign bus.xfer_valid = (state == MPURP_IDLE) && XFER_REQ;
    assign bus.xfer_addr = XFER_ADDR;
    assign bus.xfer_id = ID;
    assign bus.xfer_super = SUPER;
    assign bus.xfer_kind = XFER_KIND;
    assign REG_RDATA = rdata;
    assign XFER_BUSY = (state != MPURP_IDLE);
    assign XFER_DONE = done;
    assign XFER_ALLOW = allow;
    assign IRQ = bus.irq;
endmodule
`default_nettype wire

/* test/mpurp_properties.sv */
// Checker for the link between the protection unit and its requester end.
// Assumes the bench instantiates it once beside the interface that joins them.
`timescale 1ns/10ps
`default_nettype none
module mpurp_properties (
    input wire logic                       CLK,
    input wire logic                       ARST_N,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [mpurp_pkg::RAW-1:0]  reg_addr,
    input wire logic [mpurp_pkg::DW-1:0]   reg_wdata,
    input wire logic [mpurp_pkg::DW-1:0]   reg_rdata,
    input wire logic                       reg_super,
    input wire logic                       xfer_valid,
    input wire logic [mpurp_pkg::AW-1:0]   xfer_addr,
    input wire logic [7:0]                 xfer_id,
    input wire logic                       xfer_super,
    input wire logic [2:0]                 xfer_kind,
    input wire logic                       xfer_allow,
    input wire logic                       xfer_done,
    input wire logic                       irq
);
    import mpurp_pkg::*;
    logic [1:0]    en;
    logic [DW-1:0] perm;
    logic [2:0]    ok_kind;
    logic          fx_ok;
    logic          in_fx;
    // Shadows of the enables and the fixed permissions, updated only by the register port.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            en   <= 2'b00;
            perm <= PERM_RESET;
        end else if (reg_wr) begin
            if (reg_addr == OFS_EN_SET) en <= en | reg_wdata[1:0];
            if (reg_addr == OFS_EN_CLR) en <= en & ~reg_wdata[1:0];
            if (reg_addr == OFS_FXD_PERM && reg_super) perm <= (reg_wdata & 32'h003F_FEFF) | 32'h03C0_0000;
        end
    end
    assign ok_kind = xfer_super ? perm[5:3] : perm[2:0];
    assign in_fx   = xfer_addr >= FXD_LO && xfer_addr <= FXD_HI;
    assign fx_ok   = ((xfer_kind & ~ok_kind) == 3'b000) && (xfer_id < 8'd12 ? perm[10 + xfer_id] : perm[9]);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_enable_readback: assert property (
        reg_rd && (reg_addr == OFS_EN_SET || reg_addr == OFS_EN_CLR) |=> reg_rdata == {30'h0, $past(en)})
        else $error("enable readback differs from written enables");
    a_enstat_masked: assert property (
        reg_rd && reg_addr == OFS_EN_STAT |=> (reg_rdata & ~{30'h0, $past(en)}) == 32'h0000_0000)
        else $error("enabled status shows a disabled bit");
    a_fixed_zero: assert property (
        reg_rd && (reg_addr == OFS_FXD_START || reg_addr == OFS_FXD_END) |=> reg_rdata == 32'h0000_0000)
        else $error("fixed range bound reads nonzero");
    a_perm_guard: assert property (
        reg_rd && reg_addr == OFS_FXD_PERM |=> reg_rdata == $past(perm))
        else $error("fixed permissions differ from supervisor writes");
    a_start_page: assert property (
        reg_rd && reg_addr == OFS_PROG_BASE |=> reg_rdata[9:0] == 10'h000)
        else $error("range start page offset not zero");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data stands outside its cycle");
    a_fixed_check: assert property (
        xfer_valid && in_fx |=> xfer_done && xfer_allow == $past(fx_ok))
        else $error("fixed range verdict wrong");
    a_done_pulse: assert property (
        xfer_valid |=> xfer_done ##1 !xfer_done)
        else $error("transfer answer not a one cycle pulse");
    a_irq_enabled: assert property (
        irq |-> en != 2'b00)
        else $error("interrupt with no enable set");
    a_irq_clear: assert property (
        reg_wr && reg_addr == OFS_EN_STAT && reg_wdata[1:0] == 2'b11 && !xfer_valid |=> !irq)
        else $error("interrupt stays after status clear");
endmodule
`default_nettype wire

/* test/tb_mpu_range_permission_regs.sv */
// Self-checking bench: small-page unit and requester end joined through one interface.
// Assumes the bench alone drives the requester's user ports.
`timescale 1ns/10ps
`default_nettype none
module tb_mpu_range_permission_regs;
    import mpurp_pkg::*;
    logic          clk, arst_n, wr, rd, sup, xreq, busy, done, allow, irq, e;
    logic [RAW-1:0] addr, a;
    logic [DW-1:0] wdata, rdata, d, perm;
    logic [DW-1:0] st [6];
    logic [DW-1:0] ed [6];
    logic [7:0]    id;
    logic [AW-1:0] xaddr;
    logic [2:0]    kind, k;
    logic [1:0]    en, raw;
    int            failures, checks_done;
    mpurp_if bus_if ();
    mpurp_unit #(.LARGE_PAGE(1'b0)) mpurp_unit_inst (.CLK(clk), .ARST_N(arst_n), .bus(bus_if));
    mpurp_requester mpurp_requester_inst (.CLK(clk), .ARST_N(arst_n), .bus(bus_if), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .SUPER(sup), .ID(id), .REG_RDATA(rdata), .XFER_REQ(xreq),
        .XFER_ADDR(xaddr), .XFER_KIND(kind), .XFER_BUSY(busy), .XFER_DONE(done), .XFER_ALLOW(allow), .IRQ(irq));
    mpurp_properties mpurp_properties_inst (.CLK(clk), .ARST_N(arst_n), .reg_wr(bus_if.reg_wr),
        .reg_rd(bus_if.reg_rd), .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
        .reg_rdata(bus_if.reg_rdata), .reg_super(bus_if.reg_super), .xfer_valid(bus_if.xfer_valid),
        .xfer_addr(bus_if.xfer_addr), .xfer_id(bus_if.xfer_id), .xfer_super(bus_if.xfer_super),
        .xfer_kind(bus_if.xfer_kind), .xfer_allow(bus_if.xfer_allow), .xfer_done(bus_if.xfer_done),
        .irq(bus_if.irq));
    task automatic chk(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(string what, logic exp, logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr_reg(logic [RAW-1:0] ad, logic [DW-1:0] v, logic s);
        @(posedge clk);
        addr  <= ad;
        wdata <= v;
        sup   <= s;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [RAW-1:0] ad, output logic [DW-1:0] v);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 v = rdata;
    endtask
    task automatic xfer(logic [AW-1:0] ad, logic [7:0] i, logic s, logic [2:0] kd, logic exp);
        @(posedge clk);
        xaddr <= ad;
        id    <= i;
        sup   <= s;
        kind  <= kd;
        xreq  <= 1'b1;
        @(posedge clk);
        xreq <= 1'b0;
        #1 chk_bit("busy", 1'b1, busy);
        repeat (4) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) break;
        end
        chk_bit("done", 1'b1, done);
        chk_bit("allow", exp, allow);
    endtask
    function automatic logic exp_allow(logic [DW-1:0] p, logic [7:0] i, logic s, logic [2:0] kd);
        logic [2:0] ok;
        ok = s ? p[5:3] : p[2:0];
        return ((kd & ~ok) == 3'b000) && (i < 8'd12 ? p[10 + i] : p[9]);
    endfunction
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // A full run needs under a thousand cycles, so twenty thousand means a hang.
    initial begin
        #200_000;
        failures++;
        conclude();
    end
    initial begin
        {arst_n, wr, rd, sup, xreq, addr, wdata, id, xaddr, kind} = '0;
        d = $urandom(39326);
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(OFS_EN_SET, d); chk("enable set", 32'h0000_0000, d);
        rd_reg(OFS_FXD_START, d); chk("fixed start", 32'h0000_0000, d);
        rd_reg(OFS_FXD_END, d); chk("fixed end", 32'h0000_0000, d);
        rd_reg(OFS_FXD_PERM, d); chk("permissions", 32'h03FF_FEFF, d);
        rd_reg(OFS_PROG_BASE, d); chk("range start", 32'h8000_0000, d);
        rd_reg(8'hFC, d); chk("unmapped", 32'h0000_0000, d);
        $display("test reset done");
        en = 2'b00;
        for (int n = 0; n < 24; n++) begin
            d = $urandom;
            wr_reg(n[0] ? OFS_EN_CLR : OFS_EN_SET, d, d[5]);
            en = n[0] ? en & ~d[1:0] : en | d[1:0];
            rd_reg(n[1] ? OFS_EN_CLR : OFS_EN_SET, d); chk("enables", {30'h0, en}, d);
        end
        $display("test enables done");
        perm = 32'h03FF_FEFF;
        raw = 2'b00;
        wr_reg(OFS_EN_SET, 32'h0000_0003, 1'b0);
        en = 2'b11;
        for (int n = 0; n < 48; n++) begin
            if (n % 6 == 0) begin
                d = $urandom | 32'h0000_00C0;
                wr_reg(OFS_FXD_PERM, d, n[0]);
                if (n[0]) perm = (d & 32'h003F_FEFF) | 32'h03C0_0000;
                rd_reg(OFS_FXD_PERM, d); chk("permissions", perm, d);
            end
            d = $urandom;
            k = (d[10:9] == 2'b11) ? 3'b001 : 3'(3'b001 << d[10:9]);
            e = exp_allow(perm, {4'h0, d[19:16]}, d[8], k);
            xfer(32'hB000_0000 + {17'h0, d[14:0]}, {4'h0, d[19:16]}, d[8], k, e);
            if (!e) raw[0] = 1'b1;
            chk_bit("irq", |(raw & en), irq);
        end
        wr_reg(OFS_EN_STAT, 32'h0000_0003, 1'b0);
        rd_reg(OFS_RAW_STAT, d); chk("raw status", 32'h0000_0000, d);
        wr_reg(OFS_RAW_STAT, 32'h0000_0002, 1'b0);
        wr_reg(OFS_EN_CLR, 32'h0000_0002, 1'b0);
        #1 chk_bit("irq", 1'b0, irq);
        rd_reg(OFS_EN_STAT, d); chk("enabled status", 32'h0000_0000, d);
        rd_reg(OFS_RAW_STAT, d); chk("raw status", 32'h0000_0002, d);
        wr_reg(OFS_EN_SET, 32'h0000_0002, 1'b0);
        #1 chk_bit("irq", 1'b1, irq);
        wr_reg(OFS_EN_STAT, 32'h0000_0003, 1'b0);
        $display("test transfers done");
        for (int n = 0; n < 6; n++) begin
            st[n] = 32'h8000_0000;
            ed[n] = 32'h8001_FFFF;
        end
        for (int n = 0; n < 12; n++) begin
            a = OFS_PROG_BASE + 8'(8 * (n % 6));
            d = $urandom;
            wr_reg(a, d, n[2]);
            wr_reg(a + 8'h04, ~d, n[2]);
            if (n[2]) st[n % 6] = d & 32'hFFFF_FC00;
            if (n[2]) ed[n % 6] = ~d | 32'h0000_03FF;
            rd_reg(a, d); chk("range start", st[n % 6], d);
            rd_reg(a + 8'h04, d); chk("range end", ed[n % 6], d);
        end
        for (int n = 0; n < 6; n++) begin
            wr_reg(OFS_PROG_BASE + 8'(8 * n), 32'hFFFF_FC00, 1'b1);
            wr_reg(OFS_PROG_BASE + 8'(8 * n + 4), 32'hFFFF_FFFF, 1'b1);
        end
        for (int c = 0; c < 2; c++) begin
            wr_reg(OFS_CONFIG, 32'(c), 1'b1);
            xfer(32'h1000_0000, 8'h00, 1'b1, 3'b100, c[0]);
        end
        rd_reg(OFS_RAW_STAT, d); chk("raw status", 32'h0000_0002, d);
        $display("test ranges done");
        conclude();
    end
endmodule
`default_nettype wire
